// *** dv/mss_ctrl_model.sv ***
`timescale 1ns/10ps
module mss_ctrl_model (
    input  wire logic          sys_clk,
    input  mss_pkg::mss_ctrl_t cmd,
    output logic               sync_clear = 1'b1, jump_req = 1'b0, alt_req = 1'b0
);
    // launch away from the sampling edge
    always @(negedge sys_clk) {sync_clear, jump_req, alt_req} <= cmd;
endmodule : mss_ctrl_model

// *** dv/mss_sequencer_assertions.sv ***
`timescale 1ns/10ps
module mss_sequencer_checker (
    input wire logic sys_clk, arst_n, sync_clear, jump_req, alt_req,
    input wire logic state_bit2, state_bit1, state_bit0, phase_a_out, phase_b_out
);
    wire [4:0] o = {state_bit2, state_bit1, state_bit0, phase_a_out, phase_b_out};
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    sequence quiet_s; !sync_clear && !jump_req; endsequence
    clr_idle_a: assert property (sync_clear |=> o == 5'h00) else $error("clr");
    go_one_a: assert property (o == 5'h00 && !sync_clear |=> o == 5'h06) else $error("s0");
    one_br_a: assert property (o == 5'h06 && !sync_clear
        |=> o == ($past(jump_req) ? 5'h0E : 5'h09)) else $error("s1");
    two_br_a: assert property (o == 5'h09 && !sync_clear
        |=> o == (!$past(jump_req) ? 5'h0E : $past(alt_req) ? 5'h06 : 5'h11)) else $error("s2");
    three_br_a: assert property (o == 5'h0E && !sync_clear
        |=> o == ($past(jump_req) ? 5'h06 : 5'h11)) else $error("s3");
    dwell_jump_a: assert property (o[4] && !sync_clear && jump_req |=> o == 5'h09) else $error("d");
    dwell_hold_a: assert property (o == 5'h11 ##0 quiet_s ##1 quiet_s |=> o == 5'h16) else $error("dh");
    reset_idle_a: assert property ($rose(arst_n) |-> o == 5'h00) else $error("rst");
endmodule : mss_sequencer_checker
bind mss_sequencer mss_sequencer_checker mss_sequencer_checker_inst (.*);

// *** dv/tb_moore_step_sequencer.sv ***
`timescale 1ns/10ps
module tb_moore_step_sequencer;
    logic sys_clk = 1'b0, arst_n = 1'b0;
    logic sync_clear, jump_req, alt_req, state_bit2, state_bit1, state_bit0, phase_a_out, phase_b_out;
    mss_pkg::mss_ctrl_t cmd = 3'h4;
    int n_fail, cmp_count;
    wire [4:0] o = {state_bit2, state_bit1, state_bit0, phase_a_out, phase_b_out};
    always #5 sys_clk = ~sys_clk;
    mss_ctrl_model mss_ctrl_model_inst (.*);
    mss_sequencer mss_sequencer_inst (.*);
    task chk(input logic [4:0] seen, exp);
        cmp_count++;
        if (seen !== exp) n_fail++;
        if (seen !== exp) $display("MISMATCH %0t %h %h", $time, seen, exp);
    endtask : chk
    task step(input logic [2:0] c, input logic [4:0] e);
        cmd = c;
        @(posedge sys_clk);
        #1 chk(o, e);
    endtask : step
    task test_done;
        $display("cmp %0d fail %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done
    task t_walk;
        step(3'h0, 5'h06);
        step(3'h2, 5'h0E);
        step(3'h0, 5'h11);
        step(3'h1, 5'h16);
        step(3'h1, 5'h16);
        step(3'h2, 5'h09);
        step(3'h3, 5'h06);
        step(3'h7, 5'h00);
    endtask : t_walk
    task t_branch;
        step(3'h4, 5'h00);
        step(3'h0, 5'h06);
        step(3'h0, 5'h09);
        step(3'h2, 5'h11);
        step(3'h2, 5'h09);
        step(3'h0, 5'h0E);
        step(3'h2, 5'h06);
        step(3'h5, 5'h00);
    endtask : t_branch
    task t_reset;
        step(3'h0, 5'h06);
        @(negedge sys_clk);
        arst_n = 1'b0;
        #1 chk(o, 5'h00);
        @(negedge sys_clk);
        arst_n = 1'b1;
        @(posedge sys_clk);
        #1 chk(o, 5'h06);
    endtask : t_reset
    initial begin
        repeat (12) @(negedge sys_clk);
        arst_n = 1'b1;
        @(posedge sys_clk);
        t_walk;
        t_branch;
        t_reset;
        test_done;
    end
    initial begin
        #1000 n_fail++;
        test_done;
    end
endmodule : tb_moore_step_sequencer

// *** hdl/mss_out_decode.sv ***
`timescale 1ns/10ps

module mss_out_decode (
    // next state to decode
    input  mss_pkg::mss_state_t state,
    // decoded output word
    output mss_pkg::mss_out_t   outs
);

    always_comb begin
        case (state)
            mss_pkg::IDLE:        outs = mss_pkg::OUT_IDLE;
            mss_pkg::STEP_ONE:    outs = mss_pkg::OUT_STEP_ONE;
            mss_pkg::STEP_TWO:    outs = mss_pkg::OUT_STEP_TWO;
            mss_pkg::STEP_THREE:  outs = mss_pkg::OUT_STEP_THREE;
            mss_pkg::DWELL_FIRST: outs = mss_pkg::OUT_DWELL_FIRST;
            mss_pkg::DWELL_HOLD:  outs = mss_pkg::OUT_DWELL_HOLD;
            default:              outs = mss_pkg::OUT_IDLE;
        endcase
    end

endmodule : mss_out_decode

// *** hdl/mss_pkg.sv ***
package mss_pkg;

    // sequencer states, idle first so reset lands there
    typedef enum logic [2:0] {
        IDLE,
        STEP_ONE,
        STEP_TWO,
        STEP_THREE,
        DWELL_FIRST,
        DWELL_HOLD
    } mss_state_t;

    // control inputs sampled at the clock edge
    typedef struct packed {
        logic sync_clear;
        logic jump_req;
        logic alt_req;
    } mss_ctrl_t;

    // output word: state_bit2, state_bit1, state_bit0, phase_a_out, phase_b_out
    typedef struct packed {
        logic state_bit2;
        logic state_bit1;
        logic state_bit0;
        logic phase_a_out;
        logic phase_b_out;
    } mss_out_t;

    localparam mss_state_t RESET_STATE = IDLE;

    localparam logic [4:0] OUT_IDLE        = 5'h00;
    localparam logic [4:0] OUT_STEP_ONE    = 5'h06;
    localparam logic [4:0] OUT_STEP_TWO    = 5'h09;
    localparam logic [4:0] OUT_STEP_THREE  = 5'h0E;
    localparam logic [4:0] OUT_DWELL_FIRST = 5'h11;
    localparam logic [4:0] OUT_DWELL_HOLD  = 5'h16;
    localparam logic [4:0] OUT_RESET       = OUT_IDLE;

endpackage : mss_pkg

// *** hdl/mss_sequencer.sv ***
`timescale 1ns/10ps

module mss_sequencer (
    // clock and reset
    input  wire logic  sys_clk,
    input  wire logic  arst_n,
    // control inputs
    input  wire logic  sync_clear,
    input  wire logic  jump_req,
    input  wire logic  alt_req,
    // state code and phase outputs
    output logic       state_bit2,
    output logic       state_bit1,
    output logic       state_bit0,
    output logic       phase_a_out,
    output logic       phase_b_out
);

    mss_pkg::mss_ctrl_t  ctrl;
    mss_pkg::mss_state_t state_q;
    mss_pkg::mss_state_t state_d;
    mss_pkg::mss_out_t   outs_d;
    mss_pkg::mss_out_t   outs_q;

    assign ctrl.sync_clear = sync_clear;
    assign ctrl.jump_req   = jump_req;
    assign ctrl.alt_req    = alt_req;

    // next-state selection; if-else order gives branch priority
    always_comb begin
        state_d = state_q;
        if (ctrl.sync_clear) begin
            state_d = mss_pkg::IDLE;
        end else begin
            case (state_q)
                mss_pkg::IDLE: begin
                    state_d = mss_pkg::STEP_ONE;
                end
                mss_pkg::STEP_ONE: begin
                    if (ctrl.jump_req) begin
                        state_d = mss_pkg::STEP_THREE;
                    end else begin
                        state_d = mss_pkg::STEP_TWO;
                    end
                end
                mss_pkg::STEP_TWO: begin
                    if (ctrl.jump_req && !ctrl.alt_req) begin
                        state_d = mss_pkg::DWELL_FIRST;
                    end else if (ctrl.jump_req && ctrl.alt_req) begin
                        state_d = mss_pkg::STEP_ONE;
                    end else begin
                        state_d = mss_pkg::STEP_THREE;
                    end
                end
                mss_pkg::STEP_THREE: begin
                    if (ctrl.jump_req) begin
                        state_d = mss_pkg::STEP_ONE;
                    end else begin
                        state_d = mss_pkg::DWELL_FIRST;
                    end
                end
                mss_pkg::DWELL_FIRST: begin
                    if (ctrl.jump_req) begin
                        state_d = mss_pkg::STEP_TWO;
                    end else begin
                        state_d = mss_pkg::DWELL_HOLD;
                    end
                end
                mss_pkg::DWELL_HOLD: begin
                    if (ctrl.jump_req) begin
                        state_d = mss_pkg::STEP_TWO;
                    end else begin
                        state_d = mss_pkg::DWELL_HOLD;
                    end
                end
                default: begin
                    state_d = mss_pkg::IDLE;
                end
            endcase
        end
    end

    // outputs decoded from the next state, registered alongside it
    // output codes
    mss_out_decode u_decode (
        .state (state_d),
        .outs  (outs_d)
    );

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= mss_pkg::RESET_STATE;
            outs_q  <= mss_pkg::OUT_RESET;
        end else begin
            state_q <= state_d;
            outs_q  <= outs_d;
        end
    end

    assign state_bit2  = outs_q.state_bit2;
    assign state_bit1  = outs_q.state_bit1;
    assign state_bit0  = outs_q.state_bit0;
    assign phase_a_out = outs_q.phase_a_out;
    assign phase_b_out = outs_q.phase_b_out;

endmodule : mss_sequencer
